// ---- design/isa_port_defs.svh ----
// constants of the host bus decode and dma port
`ifndef ISA_PORT_DEFS_SVH
`define ISA_PORT_DEFS_SVH

// function indices
`define FN_CODEC 3'h0
`define FN_LEGACY 3'h1
`define FN_SYNTH 3'h2
`define FN_GAME 3'h3
`define FN_MIDI 3'h4
`define FN_CONTROL 3'h5
`define FN_CDROM 3'h6
`define FN_MODEM 3'h7

// log2 of each decode window
`define WIN_CODEC 4'h2
`define WIN_LEGACY 4'h4
`define WIN_SYNTH 4'h2
`define WIN_GAME 4'h0
`define WIN_MIDI 4'h1
`define WIN_CONTROL 4'h3
`define WIN_CDROM 4'h3
`define WIN_MODEM_MIN 4'h1
`define WIN_MODEM_MAX 4'h8

// codec and control decode twelve bits, the rest ten
`define FN_WIDE_MASK 8'h21
`define MASK10 12'h3ff
`define MASK12 12'hfff

// default bus dma lines of channels a, b and the third
`define DMA_MAP_A_RST 2'h0
`define DMA_MAP_B_RST 2'h1
`define DMA_MAP_C_RST 2'h3

`define FIFO_DEPTH 16
`define DATA_W 8

`endif

// ---- design/isa_port_pkg.sv ----
// types of the host bus decode and dma port
package isa_port_pkg;

	typedef enum logic [1:0] {
		CH_IDLE = 2'b00,
		CH_REQ = 2'b01,
		CH_XFER = 2'b11
	} dma_state_e;

	typedef struct packed {
		logic [15:0] sa;
		logic aen;
		logic ior_n;
		logic iow_n;
		logic [3:0] dack_n;
		logic [7:0] data;
	} bus_pins_s;

	typedef struct packed {
		logic [7:0] act;
		logic [7:0][11:0] base;
		logic [11:0] cd_alt_base;
		logic [3:0] modem_win;
		logic dec16;
		logic dma_request_timing_select;
		logic [2:0][1:0] map;
	} cfg_s;

	typedef struct packed {
		logic req;
		logic to_host;
		logic [7:0] len_m1;
	} dma_req_s;

	typedef struct packed {
		logic is_dma;
		logic [2:0] idx;
		logic [7:0] offset;
		logic [7:0] data;
	} xfer_word_s;

	typedef struct packed {
		logic valid;
		logic is_dma;
		logic [2:0] idx;
		logic [7:0] offset;
	} rd_req_s;

	typedef struct packed {
		logic prev_ior_n;
		logic prev_iow_n;
		logic [7:0] data;
		logic data_oe;
		logic [3:0] drq;
		dma_state_e [2:0] ch;
		logic [2:0] ch_drq;
		logic [2:0][7:0] cnt;
		logic [2:0][7:0] len;
		logic [2:0] dir;
		logic [2:0][1:0] map;
		logic [7:0] sel;
		logic cdrom_sel;
		logic modem_sel;
		logic [2:0] periph_addr;
		rd_req_s rd;
		xfer_word_s wword;
		logic wvalid;
		logic ovr;
	} port_state_s;

endpackage : isa_port_pkg

// ---- design/pin_sync.sv ----
// three-stage synchroniser for bus pins, a change counts once stages two and three agree
`timescale 1ns/100ps
module pin_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] RST = '0
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rstn_i,
	// pins
	input wire logic [W-1:0] d_i,
	output logic [W-1:0] q_o
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] q;
	} sync_s;

	localparam sync_s SYNC_RST = '{s1: RST, s2: RST, s3: RST, q: RST};

	sync_s st_r;
	sync_s st_nxt;

	// stage one feeds stage two only
	always_comb begin
		st_nxt = st_r;
		st_nxt.s1 = d_i;
		st_nxt.s2 = st_r.s1;
		st_nxt.s3 = st_r.s2;
		st_nxt.q = (st_r.s2 ~^ st_r.s3) & st_r.s3 | (st_r.s2 ^ st_r.s3) & st_r.q;
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			st_r <= SYNC_RST;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign q_o = st_r.q;
endmodule : pin_sync

// ---- design/xfer_fifo.sv ----
// shift fifo whose head is always entry zero, so the read side is registered
`timescale 1ns/100ps
module xfer_fifo #(
	parameter int W = 20,
	parameter int DEPTH = 16
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rstn_i,
	// fill side
	input wire logic in_valid_i,
	input wire logic [W-1:0] in_data_i,
	output logic in_ready_o,
	// drain side
	output logic out_valid_o,
	output logic [W-1:0] out_data_o,
	input wire logic out_ready_i
);
	localparam int CW = $clog2(DEPTH + 1);

	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem;
		logic [CW-1:0] cnt;
		logic full;
		logic nonempty;
	} fifo_s;

	fifo_s st_r;
	fifo_s st_nxt;
	logic push;
	logic pop;
	logic [CW-1:0] wr_idx;

	assign push = in_valid_i && !st_r.full;
	assign pop = out_ready_i && st_r.nonempty;
	assign wr_idx = st_r.cnt - CW'(pop);

	always_comb begin
		st_nxt = st_r;
		if (pop) begin
			for (int i = 0; i < DEPTH - 1; i++) begin
				st_nxt.mem[i] = st_r.mem[i + 1];
			end
		end
		for (int i = 0; i < DEPTH; i++) begin
			if (push && wr_idx == CW'(i)) begin
				st_nxt.mem[i] = in_data_i;
			end
		end
		st_nxt.cnt = st_r.cnt + CW'(push) - CW'(pop);
		st_nxt.full = st_nxt.cnt == CW'(DEPTH);
		st_nxt.nonempty = st_nxt.cnt != '0;
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign in_ready_o = !st_r.full;
	assign out_valid_o = st_r.nonempty;
	assign out_data_o = st_r.mem[0];
endmodule : xfer_fifo

// ---- design/isa_io_decode_and_dma_port.sv ----
// host bus i/o decode, read and write data handling and byte dma request port
`timescale 1ns/100ps
`include "isa_port_defs.svh"

module isa_io_decode_and_dma_port
	import isa_port_pkg::*;
(
	// clock and reset
	input wire logic clk_i,
	input wire logic rstn_i,
	// bus pins
	input wire logic [15:0] sa_i,
	input wire logic aen_i,
	input wire logic ior_n_i,
	input wire logic iow_n_i,
	input wire logic [3:0] dack_n_i,
	input wire logic [`DATA_W-1:0] data_i,
	output logic [`DATA_W-1:0] data_o,
	output logic data_oe_o,
	output logic [3:0] drq_o,
	// configuration
	input wire cfg_s cfg_i,
	input wire logic map_load_i,
	// function side
	input wire logic [`DATA_W-1:0] rdata_i,
	output rd_req_s rd_req_o,
	output logic [7:0] fn_sel_o,
	input wire dma_req_s [2:0] dma_req_i,
	// external peripheral port
	output logic cdrom_sel_o,
	output logic modem_sel_o,
	output logic [2:0] periph_addr_o,
	// write stream
	output logic wr_valid_o,
	output xfer_word_s wr_word_o,
	input wire logic wr_ready_i,
	output logic ovr_o
);
	localparam bus_pins_s PIN_RST = '{sa: 16'h0, aen: 1'b1, ior_n: 1'b1, iow_n: 1'b1,
		dack_n: 4'hf, data: 8'h0};
	localparam logic [7:0][3:0] WIN = {`WIN_MODEM_MIN, `WIN_CDROM, `WIN_CONTROL, `WIN_MIDI,
		`WIN_GAME, `WIN_SYNTH, `WIN_LEGACY, `WIN_CODEC};
	localparam logic [7:0] WIDE = `FN_WIDE_MASK;
	localparam port_state_s ST_RST = '{
		prev_ior_n: 1'b1,
		prev_iow_n: 1'b1,
		ch: '{CH_IDLE, CH_IDLE, CH_IDLE},
		map: {`DMA_MAP_C_RST, `DMA_MAP_B_RST, `DMA_MAP_A_RST},
		default: '0
	};

	bus_pins_s p;
	port_state_s st_r;
	port_state_s st_nxt;
	logic [7:0] hit;
	logic [3:0] dack_act;
	logic any_dack;
	logic io_ok;
	logic io_cyc;
	logic iow_rise;
	logic strb_rise;
	logic strb_fall;
	logic [2:0] grant;
	logic [2:0] last;
	logic [2:0] fn_idx;
	logic [3:0] modem_w;
	logic fifo_ready;
	logic all_idle;

	function automatic logic fn_hit(input logic [15:0] sa, input logic [11:0] base,
		input logic [3:0] w, input logic wide);
		logic [11:0] low;
		logic [11:0] mask;
		low = 12'((13'h1 << w) - 13'h1);
		mask = (wide ? `MASK12 : `MASK10) & ~low;
		fn_hit = (((sa[11:0] ^ base) & mask) == 12'h0) && (wide || sa[11:10] == 2'h0);
	endfunction : fn_hit

	// pins cross into the clock domain; address, aen and data share the strobe delay
	pin_sync #(
		.W($bits(bus_pins_s)),
		.RST(PIN_RST)
	) u_sync (
		.clk_i(clk_i),
		.rstn_i(rstn_i),
		.d_i({sa_i, aen_i, ior_n_i, iow_n_i, dack_n_i, data_i}),
		.q_o(p)
	);

	assign dack_act = ~p.dack_n;
	assign any_dack = |dack_act;
	assign io_ok = !p.aen && !any_dack;
	assign io_cyc = (|hit) && io_ok;
	assign iow_rise = !st_r.prev_iow_n && p.iow_n;
	assign strb_rise = iow_rise || (!st_r.prev_ior_n && p.ior_n);
	assign strb_fall = (st_r.prev_iow_n && !p.iow_n) || (st_r.prev_ior_n && !p.ior_n);
	assign all_idle = st_r.ch[0] == CH_IDLE && st_r.ch[1] == CH_IDLE && st_r.ch[2] == CH_IDLE;
	assign modem_w = (cfg_i.modem_win < `WIN_MODEM_MIN) ? `WIN_MODEM_MIN :
		(cfg_i.modem_win > `WIN_MODEM_MAX) ? `WIN_MODEM_MAX : cfg_i.modem_win;

	// address decode of all eight functions
	always_comb begin
		hit = 8'h0;
		for (int i = 0; i < 8; i++) begin
			hit[i] = fn_hit(p.sa, cfg_i.base[i], (i == 7) ? modem_w : WIN[i], WIDE[i]);
		end
		hit[`FN_CDROM] = hit[`FN_CDROM] ||
			fn_hit(p.sa, cfg_i.cd_alt_base, `WIN_CDROM, 1'b0);
		if (cfg_i.dec16) begin
			hit[`FN_CDROM] = 1'b0;
			hit[`FN_MODEM] = 1'b0;
			if (p.sa[15:12] != 4'h0) begin
				hit = 8'h0;
			end
		end
		hit = hit & cfg_i.act;
	end

	always_comb begin
		fn_idx = 3'h0;
		for (int i = 7; i >= 0; i--) begin
			if (hit[i]) begin
				fn_idx = 3'(i);
			end
		end
	end

	// dma channel n owns a cycle only when its own mapped line is acknowledged
	always_comb begin
		for (int c = 0; c < 3; c++) begin
			grant[c] = (st_r.ch[c] != CH_IDLE) && dack_act[st_r.map[c]];
			last[c] = st_r.cnt[c] == st_r.len[c];
		end
	end

	always_comb begin
		st_nxt = st_r;
		st_nxt.prev_ior_n = p.ior_n;
		st_nxt.prev_iow_n = p.iow_n;
		st_nxt.data_oe = 1'b0;
		st_nxt.wvalid = 1'b0;
		st_nxt.rd.valid = 1'b0;
		st_nxt.sel = io_cyc ? hit : 8'h0;
		st_nxt.cdrom_sel = io_cyc && hit[`FN_CDROM];
		st_nxt.modem_sel = io_cyc && hit[`FN_MODEM];
		if (io_cyc && (hit[`FN_CDROM] || hit[`FN_MODEM])) begin
			st_nxt.periph_addr = p.sa[2:0];
		end
		// a byte refused by a full fifo is lost; the sticky flag reports it
		if (st_r.wvalid && !fifo_ready) begin
			st_nxt.ovr = 1'b1;
		end
		if (io_cyc && !p.ior_n) begin
			st_nxt.data_oe = 1'b1;
			st_nxt.data = rdata_i;
			st_nxt.rd = '{valid: 1'b1, is_dma: 1'b0, idx: fn_idx, offset: p.sa[7:0]};
		end
		if (io_cyc && iow_rise) begin
			st_nxt.wvalid = 1'b1;
			st_nxt.wword = '{is_dma: 1'b0, idx: fn_idx, offset: p.sa[7:0], data: p.data};
		end
		for (int c = 0; c < 3; c++) begin
			unique case (st_r.ch[c])
				CH_IDLE: begin
					// playback requests wait for fifo room, which stalls the source
					if (dma_req_i[c].req && (dma_req_i[c].to_host || fifo_ready)) begin
						st_nxt.ch[c] = CH_REQ;
						st_nxt.ch_drq[c] = 1'b1;
						st_nxt.len[c] = dma_req_i[c].len_m1;
						st_nxt.dir[c] = dma_req_i[c].to_host;
						st_nxt.cnt[c] = 8'h0;
					end
				end
				CH_REQ: begin
					if (grant[c]) begin
						st_nxt.ch[c] = CH_XFER;
					end
				end
				CH_XFER: begin
				end
				default: begin
					st_nxt.ch[c] = CH_IDLE;
					st_nxt.ch_drq[c] = 1'b0;
				end
			endcase
			if (grant[c]) begin
				if (st_r.dir[c] && !p.ior_n) begin
					st_nxt.data_oe = 1'b1;
					st_nxt.data = rdata_i;
					st_nxt.rd = '{valid: 1'b1, is_dma: 1'b1, idx: 3'(c), offset: 8'h0};
				end
				if (!st_r.dir[c] && iow_rise) begin
					st_nxt.wvalid = 1'b1;
					st_nxt.wword = '{is_dma: 1'b1, idx: 3'(c), offset: 8'h0, data: p.data};
				end
				if (strb_rise) begin
					st_nxt.cnt[c] = st_r.cnt[c] + 8'h1;
					if (last[c]) begin
						st_nxt.ch[c] = CH_IDLE;
						st_nxt.ch_drq[c] = 1'b0;
					end
				end else if (strb_fall && last[c] && !cfg_i.dma_request_timing_select) begin
					st_nxt.ch_drq[c] = 1'b0;
				end
			end
		end
		// remapping while a request is open would move it between bus lines
		if (map_load_i && all_idle) begin
			st_nxt.map = cfg_i.map;
		end
		st_nxt.drq = 4'h0;
		for (int c = 0; c < 3; c++) begin
			if (st_nxt.ch_drq[c]) begin
				st_nxt.drq[st_nxt.map[c]] = 1'b1;
			end
		end
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			st_r <= ST_RST;
		end else begin
			st_r <= st_nxt;
		end
	end

	xfer_fifo #(
		.W($bits(xfer_word_s)),
		.DEPTH(`FIFO_DEPTH)
	) u_fifo (
		.clk_i(clk_i),
		.rstn_i(rstn_i),
		.in_valid_i(st_r.wvalid),
		.in_data_i(st_r.wword),
		.in_ready_o(fifo_ready),
		.out_valid_o(wr_valid_o),
		.out_data_o(wr_word_o),
		.out_ready_i(wr_ready_i)
	);

	assign data_o = st_r.data;
	assign data_oe_o = st_r.data_oe;
	assign drq_o = st_r.drq;
	assign rd_req_o = st_r.rd;
	assign fn_sel_o = st_r.sel;
	assign cdrom_sel_o = st_r.cdrom_sel;
	assign modem_sel_o = st_r.modem_sel;
	assign periph_addr_o = st_r.periph_addr;
	assign ovr_o = st_r.ovr;

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rstn_i);

	sequence s_ch0_granted;
		st_r.ch[0] == CH_REQ && grant[0];
	endsequence

	sequence s_ch0_final_rise;
		st_r.ch[0] != CH_IDLE && grant[0] && last[0] && strb_rise;
	endsequence

	io_cycle_gate_a: assert property ((st_r.rd.valid && !st_r.rd.is_dma) |-> $past(io_ok))
		else $error("i/o read answered without a clean i/o cycle");
	read_drive_a: assert property ((io_cyc && !p.ior_n) |=> st_r.data_oe && st_r.data == $past(rdata_i))
		else $error("decoded read not driven");
	write_capture_a: assert property ((io_cyc && iow_rise) |=> st_r.wvalid && st_r.wword.data == $past(p.data))
		else $error("written byte not captured at strobe rise");
	no_alias_a: assert property ((|(hit & ~WIDE)) |-> p.sa[11:10] == 2'h0)
		else $error("ten-bit function hit with a10 or a11 set");
	upper_zero_a: assert property ((cfg_i.dec16 && |hit) |-> p.sa[15:12] == 4'h0)
		else $error("hit with upper address bits set");
	periph_off_a: assert property (cfg_i.dec16 |=> !st_r.cdrom_sel && !st_r.modem_sel)
		else $error("cdrom or modem selected in sixteen-bit decode");
	dma_noaddr_a: assert property (any_dack |=> st_r.sel == 8'h0)
		else $error("function selected during dma acknowledge");
	drq_route_a: assert property (st_r.ch_drq[0] |-> st_r.drq[st_r.map[0]])
		else $error("channel request not on its mapped line");
	ack_step_a: assert property (s_ch0_granted |=> st_r.ch[0] == CH_XFER)
		else $error("acknowledged channel did not enter transfer");
	drq_hold_a: assert property ($fell(st_r.ch_drq[0]) |-> $past(grant[0] && last[0]))
		else $error("request dropped before the last byte");
	burst_end_a: assert property (s_ch0_final_rise |=> st_r.ch[0] == CH_IDLE ##1 !st_r.drq[st_r.map[0]] || st_r.ch_drq[0])
		else $error("channel not released after its last byte");
	inactive_a: assert property ((hit & ~cfg_i.act) == 8'h0)
		else $error("inactive function decoded");
	quiet_bus_a: assert property (st_r.data_oe |-> $past(!p.ior_n) && $past(io_cyc || |grant))
		else $error("data driven outside a read");
	modem_addr_a: assert property ((io_cyc && hit[`FN_MODEM]) |=> st_r.modem_sel && st_r.periph_addr == $past(p.sa[2:0]))
		else $error("modem address bits not passed");
endmodule : isa_io_decode_and_dma_port

// ---- bench/host_bus_model.sv ----
// host processor and dma controller model driving the expansion bus pins
`timescale 1ns/100ps
module host_bus_model (
	// clock
	input wire logic clk_i,
	// bus pins
	output logic [15:0] sa_o,
	output logic aen_o,
	output logic ior_n_o,
	output logic iow_n_o,
	output logic [3:0] dack_n_o,
	output logic [7:0] data_o
);
	initial begin
		{sa_o, aen_o, ior_n_o, iow_n_o, dack_n_o, data_o} = {16'h0000, 3'b011, 4'hf, 8'h00};
	end

	// address, aen and dack settle a full cycle before the strobe falls
	task automatic start(input logic [15:0] a, input logic aen, input logic [3:0] dk,
		input logic wr, input logic [7:0] d);
		@(negedge clk_i);
		sa_o = a;
		aen_o = aen;
		dack_n_o = dk;
		data_o = wr ? d : ~data_o;
		@(negedge clk_i);
		if (wr)
			iow_n_o = 1'b0;
		else
			ior_n_o = 1'b0;
	endtask : start

	// data and address outlive the strobe rise; undriven data then shows the inverse
	task automatic finish();
		@(negedge clk_i);
		ior_n_o = 1'b1;
		iow_n_o = 1'b1;
		repeat (2) @(negedge clk_i);
		dack_n_o = 4'hf;
		data_o = ~data_o;
		repeat (4) @(negedge clk_i);
	endtask : finish
endmodule : host_bus_model

// ---- bench/isa_io_decode_and_dma_port_tb.sv ----
// self-checking bench of the host bus decode and dma port
`timescale 1ns/100ps
`include "isa_port_defs.svh"
module isa_io_decode_and_dma_port_tb;
	import isa_port_pkg::*;
	logic clk_i, rstn_i, aen, ior_n, iow_n, data_oe, map_load, cdrom_sel, modem_sel;
	logic wr_valid, wr_ready, ovr, stall;
	logic [15:0] sa, a;
	logic [3:0] dack_n, drq;
	logic [7:0] bdata, data_o, rdata, fn_sel;
	logic [2:0] paddr;
	cfg_s cfg;
	rd_req_s rd_req;
	dma_req_s [2:0] dreq;
	xfer_word_s wword;
	logic [7:0] fifo_q [$];
	logic [15:0] msk [4] = '{16'h0003, 16'h000f, 16'h0c00, 16'hf000};
	int n_errors = 0;
	int n_compared = 0;
	int k;

	host_bus_model host (.clk_i(clk_i), .sa_o(sa), .aen_o(aen), .ior_n_o(ior_n),
		.iow_n_o(iow_n), .dack_n_o(dack_n), .data_o(bdata));

	isa_io_decode_and_dma_port dut (.clk_i(clk_i), .rstn_i(rstn_i), .sa_i(sa), .aen_i(aen),
		.ior_n_i(ior_n), .iow_n_i(iow_n), .dack_n_i(dack_n), .data_i(bdata), .data_o(data_o),
		.data_oe_o(data_oe), .drq_o(drq), .cfg_i(cfg), .map_load_i(map_load), .rdata_i(rdata),
		.rd_req_o(rd_req), .fn_sel_o(fn_sel), .dma_req_i(dreq), .cdrom_sel_o(cdrom_sel),
		.modem_sel_o(modem_sel), .periph_addr_o(paddr), .wr_valid_o(wr_valid),
		.wr_word_o(wword), .wr_ready_i(wr_ready), .ovr_o(ovr));

	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_errors++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic end_of_test();
		$display("compared %0d, errors %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : end_of_test

	// lowest enabled function whose window holds the address, one-hot
	function automatic logic [7:0] exp_sel(input logic [15:0] ad);
		logic [3:0] w [8] = '{`WIN_CODEC, `WIN_LEGACY, `WIN_SYNTH, `WIN_GAME, `WIN_MIDI,
			`WIN_CONTROL, `WIN_CDROM, `WIN_MODEM_MIN};
		logic [7:0] hit;
		w[7] = cfg.modem_win;
		for (int i = 0; i < 8; i++)
			hit[i] = cfg.act[i] && (ad[11:0] >> w[i]) == (cfg.base[i] >> w[i]);
		hit[6] |= cfg.act[6] && (ad[11:0] >> 3) == (cfg.cd_alt_base >> 3);
		if (cfg.dec16)
			hit = (ad[15:12] == 4'h0) ? hit & 8'h3f : 8'h00;
		return hit & (~hit + 8'h01);
	endfunction : exp_sel

	// waits for the head of the write stream, checks it, then lets it pop
	task automatic wait_word(input logic dma, input logic [7:0] d, input logic [10:0] loc);
		int n = 0;
		while (wr_valid !== 1'b1 && n < 12) begin
			@(negedge clk_i);
			n++;
		end
		check({wr_valid, wword.is_dma, wword.data}, {1'b1, dma, d});
		if (!dma)
			check({wword.idx, wword.offset}, loc);
		// the head stands until this one-cycle ready pops it
		wr_ready = 1'b1;
		@(negedge clk_i);
		wr_ready = 1'b0;
	endtask : wait_word

	task automatic io_read(input logic [15:0] ad, input logic ae, input logic [3:0] dk);
		logic [7:0] e;
		logic ok;
		e = exp_sel(ad);
		ok = e != 8'h00 && !ae && dk == 4'hf;
		rdata = 8'($urandom);
		host.start(ad, ae, dk, 1'b0, 8'h00);
		repeat (7) @(negedge clk_i);
		check({data_oe, rd_req.valid}, {ok, ok});
		check({cdrom_sel, modem_sel}, ok ? {e[6], e[7]} : 2'b00);
		if (ok)
			check({fn_sel, data_o}, {e, rdata});
		if (ok && (e[6] || e[7]))
			check(paddr, ad[2:0]);
		host.finish();
		check(data_oe, 1'b0);
	endtask : io_read

	task automatic io_write(input logic [15:0] ad, input logic [7:0] d);
		logic [7:0] e;
		e = exp_sel(ad);
		host.start(ad, 1'b0, 4'hf, 1'b1, d);
		repeat (5) @(negedge clk_i);
		host.finish();
		if (e == 8'h00) begin
			repeat (4) @(negedge clk_i);
			check(wr_valid, 1'b0);
		end else if (!stall) begin
			wait_word(1'b0, d, {3'($clog2(e)), ad[7:0]});
		end
	endtask : io_write

	task automatic dma_run(input int c, input logic [1:0] ln, input logic th,
		input logic [7:0] m1, input logic dts);
		cfg.dma_request_timing_select = dts;
		dreq[c] = {1'b1, th, m1};
		repeat (3) @(negedge clk_i);
		check(drq, 4'h1 << ln);
		dreq[c].req = 1'b0;
		for (int b = 0; b <= m1; b++) begin
			// random address under dack must not matter
			host.start(16'($urandom), 1'b1, ~(4'h1 << ln), !th, 8'(b + 7));
			repeat (7) @(negedge clk_i);
			check(drq, (b < m1 || dts) ? 4'h1 << ln : 4'h0);
			if (th)
				check(data_oe, 1'b1);
			host.finish();
			check(drq, (b < m1) ? 4'h1 << ln : 4'h0);
			if (!th)
				wait_word(1'b1, 8'(b + 7), 11'h000);
		end
	endtask : dma_run

	initial begin
		#100000;
		n_errors++;
		end_of_test();
	end

	initial begin
		void'($urandom(10));
		{rstn_i, map_load, wr_ready, stall, rdata, dreq} = '0;
		cfg = '0;
		repeat (4) @(negedge clk_i);
		rstn_i = 1'b1;
		repeat (2) @(negedge clk_i);
		check({drq, data_oe, wr_valid, ovr, rd_req.valid}, 8'h00);
		io_read(16'h0220, 1'b0, 4'hf);
		// functions are configured only after a first read that finds them all inactive
		cfg.base = {12'h2f8, 12'h170, 12'h938, 12'h330, 12'h201, 12'h388, 12'h220, 12'hd34};
		cfg.cd_alt_base = 12'h370;
		cfg.modem_win = 4'h3;
		cfg.map = {`DMA_MAP_C_RST, `DMA_MAP_B_RST, `DMA_MAP_A_RST};
		cfg.act = 8'hff;
		io_read(16'h0620, 1'b0, 4'hf);
		io_read(16'h0134, 1'b0, 4'hf);
		for (int i = 0; i < 60; i++) begin
			k = $urandom_range(0, 8);
			cfg.dec16 = i >= 40;
			cfg.act = (i % 10 == 9) ? 8'($urandom) : 8'hff;
			a = {4'h0, (k < 8) ? cfg.base[k] : cfg.cd_alt_base};
			a = a ^ (16'($urandom) & msk[$urandom_range(0, 3)]);
			if ($urandom_range(0, 1))
				io_read(a, $urandom_range(0, 7) == 0, ($urandom_range(0, 7) == 0) ? 4'he : 4'hf);
			else
				io_write(a, 8'($urandom));
		end
		cfg.act = 8'hff;
		cfg.dec16 = 1'b0;
		// fill the write stream while it stalls, then drain it
		stall = 1'b1;
		for (int i = 0; i < 18; i++) begin
			fifo_q.push_back(8'(i * 13));
			io_write(16'h0d34, fifo_q[i]);
			if (i == 14)
				check(ovr, 1'b0);
		end
		check(ovr, 1'b1);
		stall = 1'b0;
		for (int i = 0; i < 16; i++)
			wait_word(1'b0, fifo_q[i], 11'h034);
		repeat (3) @(negedge clk_i);
		check(wr_valid, 1'b0);
		dma_run(0, 2'h0, 1'b0, 8'h00, 1'b0);
		dma_run(1, 2'h1, 1'b1, 8'($urandom_range(1, 3)), 1'b0);
		dma_run(2, 2'h3, 1'b0, 8'($urandom_range(1, 3)), 1'b1);
		cfg.map = {2'h0, 2'h3, 2'h2};
		map_load = 1'b1;
		@(negedge clk_i);
		map_load = 1'b0;
		dma_run(0, 2'h2, 1'b1, 8'h02, 1'b1);
		end_of_test();
	end
endmodule : isa_io_decode_and_dma_port_tb
